// ---- design/ptc_device.sv ----
// device end: registers, gain table, correction, overload, replies
// assumes link pins are asynchronous, sensor data on the same clock
`timescale 1ns/1ns
`include "ptc_params.svh"
module ptc_device #(
  parameter int RETRY_CYC = `PTC_RETRY_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  ptc_link_if.dev link,
  // sensor side
  input wire logic signed [7:0] tempC,
  input wire ptc_pkg::ptc_word_t proxRaw,
  input wire logic highSideOver,
  input wire logic lowSideOver,
  // outputs
  output logic detect,
  output logic switchDrive,
  output logic ledOn,
  output logic ledCurrentHigh,
  output logic npnMode
);
  import ptc_pkg::*;

  // *******************
  // input synchronisers
  // *******************
  logic cfgMeta_r, cfgS_r, hiMeta_r, hiS_r, loMeta_r, loS_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      cfgMeta_r <= 1'b1;
      cfgS_r <= 1'b1;
      hiMeta_r <= 1'b0;
      hiS_r <= 1'b0;
      loMeta_r <= 1'b0;
      loS_r <= 1'b0;
    end else begin
      cfgMeta_r <= link.cfgLine;
      cfgS_r <= cfgMeta_r;
      hiMeta_r <= highSideOver;
      hiS_r <= hiMeta_r;
      loMeta_r <= lowSideOver;
      loS_r <= loMeta_r;
    end
  end

  // *******************
  // link receiver and replier
  // *******************
  ptc_rx_t rx_r;
  logic [15:0] cnt_r;
  logic [4:0] bitCnt_r;
  logic [16:0] shift_r;
  logic [7:0] txSh_r;
  logic indSink_r;
  logic frameDone;
  logic [16:0] frameNow;
  ptc_byte_t rdData;
  assign frameDone = (rx_r == RX_BITS) && (cnt_r == 16'h0000) &&
                     (bitCnt_r == 5'(`PTC_FRAME_BITS - 1));
  assign frameNow = {shift_r[15:0], cfgS_r};

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_r <= RX_IDLE;
      cnt_r <= 16'h0000;
      bitCnt_r <= 5'h00;
      shift_r <= 17'h00000;
      txSh_r <= 8'h00;
      indSink_r <= 1'b0;
    end else begin
      unique case (rx_r)
        RX_IDLE: begin
          indSink_r <= 1'b0;
          if (!cfgS_r) begin
            rx_r <= RX_START;
            cnt_r <= 16'(`PTC_HALF_CYC - 1);
          end
        end
        RX_START: begin
          // a glitch shorter than half a bit is dropped
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (!cfgS_r) begin
            rx_r <= RX_BITS;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
            bitCnt_r <= 5'h00;
          end else begin
            rx_r <= RX_IDLE;
          end
        end
        RX_BITS: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            shift_r <= frameNow;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
            bitCnt_r <= bitCnt_r + 5'h01;
            if (frameDone) begin
              rx_r <= RX_STOP;
              txSh_r <= rdData;
            end
          end
        end
        RX_STOP: begin
          // waits to the middle of the stop bit so a low last bit is no new start
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (shift_r[16]) begin
            rx_r <= RX_IDLE;
          end else begin
            rx_r <= TX_START;
            indSink_r <= 1'b1;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
          end
        end
        TX_START: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            rx_r <= TX_BITS;
            indSink_r <= txSh_r[7];
            txSh_r <= {txSh_r[6:0], 1'b0};
            bitCnt_r <= 5'h01;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
          end
        end
        TX_BITS: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (bitCnt_r == 5'(`PTC_REPLY_BITS)) begin
            rx_r <= RX_IDLE;
            indSink_r <= 1'b0;
          end else begin
            indSink_r <= txSh_r[7];
            txSh_r <= {txSh_r[6:0], 1'b0};
            bitCnt_r <= bitCnt_r + 5'h01;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
          end
        end
        default: rx_r <= RX_IDLE;
      endcase
    end
  end
  assign link.indSink = indSink_r;

  // *******************
  // register and table writes
  // *******************
  logic wrEn;
  ptc_byte_t wrAddr, wrData, lutOfs;
  logic lutHit;
  logic [5:0] lutWrIdx;
  ptc_word_t thr_r;
  logic [1:0] cfg_r;
  ptc_word_t lut_r [`PTC_LUT_N];
  assign wrEn = frameDone && frameNow[16];
  assign wrAddr = frameNow[15:8];
  assign wrData = frameNow[7:0];
  assign lutOfs = wrAddr - `PTC_A_LUT;
  assign lutHit = (wrAddr >= `PTC_A_LUT) &&
                  (lutOfs < 8'(2 * `PTC_LUT_N));
  assign lutWrIdx = lutOfs[6:1];

  always_ff @(posedge clock) begin
    if (rst) begin
      thr_r <= `PTC_THR_RST;
      cfg_r <= 2'b00;
    end else if (wrEn) begin
      if (wrAddr == `PTC_A_THR_HI) thr_r[15:8] <= wrData;
      if (wrAddr == `PTC_A_THR_LO) thr_r[7:0] <= wrData;
      if (wrAddr == `PTC_A_CFG) cfg_r <= wrData[1:0];
    end
  end

  // reset loads the default curve, writes recalibrate it
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `PTC_LUT_N; i++) begin
        lut_r[i] <= `PTC_GAIN_RST;
      end
    end else if (wrEn && lutHit) begin
      if (lutOfs[0]) lut_r[lutWrIdx][7:0] <= wrData;
      else lut_r[lutWrIdx][15:8] <= wrData;
    end
  end

  // *******************
  // temperature, table lookup and correction
  // *******************
  ptc_byte_t temp_r, tempDelta;
  logic [5:0] lutIdx;
  ptc_word_t gain, corr;
  logic [31:0] prod;
  always_ff @(posedge clock) begin
    if (rst) temp_r <= 8'h00;
    // below -64 the offset reading would wrap, so it floors at 0
    else if (tempC < -8'sh40) temp_r <= 8'h00;
    else temp_r <= 8'(tempC) + `PTC_TEMP_OFS;
  end

  // one entry per 4 degrees from the lowest point
  assign tempDelta = temp_r - `PTC_LUT_CODE0;
  always_comb begin
    if (temp_r < `PTC_LUT_CODE0) lutIdx = 6'd0;
    else if (tempDelta[7:2] > 6'(`PTC_LUT_N - 1))
      lutIdx = 6'(`PTC_LUT_N - 1);
    else lutIdx = tempDelta[7:2];
  end
  assign gain = lut_r[lutIdx];

  // gain 0x4000 is unity, top of range near four
  assign prod = proxRaw * gain;
  assign corr = (prod[31:30] != 2'b00) ? 16'hffff :
                prod[`PTC_GAIN_FRAC +: 16];

  // *******************
  // read mux for replies
  // *******************
  always_comb begin
    rdData = 8'h00;
    if (lutHit) begin
      rdData = lutOfs[0] ? lut_r[lutWrIdx][7:0] : lut_r[lutWrIdx][15:8];
    end else begin
      unique case (wrAddr)
        `PTC_A_THR_HI: rdData = thr_r[15:8];
        `PTC_A_THR_LO: rdData = thr_r[7:0];
        `PTC_A_CFG: rdData = {6'h00, cfg_r};
        `PTC_A_TEMP: rdData = temp_r;
        `PTC_A_PROX_HI: rdData = proxRaw[15:8];
        `PTC_A_PROX_LO: rdData = proxRaw[7:0];
        default: rdData = 8'h00;
      endcase
    end
  end

  // *******************
  // overload protection
  // *******************
  ptc_ol_t ol_r;
  logic [16:0] olCnt_r;
  logic overNow;
  // only the sense input of the chosen mode counts
  assign overNow = cfg_r[`PTC_CFG_NPN] ? loS_r : hiS_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ol_r <= OL_RUN;
      olCnt_r <= 17'h00000;
    end else begin
      unique case (ol_r)
        OL_RUN: begin
          if (overNow) begin
            ol_r <= OL_WAIT;
            olCnt_r <= 17'(RETRY_CYC - 1);
          end
        end
        OL_WAIT: begin
          if (olCnt_r != 17'h00000) begin
            olCnt_r <= olCnt_r - 17'h00001;
          end else begin
            ol_r <= OL_TEST;
            olCnt_r <= 17'(`PTC_TEST_CYC - 1);
          end
        end
        OL_TEST: begin
          // the pulse runs its full length before the sense is judged
          if (olCnt_r != 17'h00000) begin
            olCnt_r <= olCnt_r - 17'h00001;
          end else if (overNow) begin
            ol_r <= OL_WAIT;
            olCnt_r <= 17'(RETRY_CYC - 1);
          end else begin
            ol_r <= OL_RUN;
          end
        end
        default: ol_r <= OL_RUN;
      endcase
    end
  end

  // *******************
  // registered outputs
  // *******************
  always_ff @(posedge clock) begin
    if (rst) begin
      detect <= 1'b0;
      switchDrive <= 1'b0;
      ledOn <= 1'b0;
      ledCurrentHigh <= 1'b0;
      npnMode <= 1'b0;
    end else begin
      detect <= corr >= thr_r;
      switchDrive <= (ol_r == OL_TEST) ||
                     ((ol_r == OL_RUN) && !overNow && corr >= thr_r);
      // the pin belongs to the reply while a reply runs
      ledOn <= (corr >= thr_r) && (rx_r != TX_START) &&
               (rx_r != TX_BITS);
      ledCurrentHigh <= cfg_r[`PTC_CFG_LED5];
      npnMode <= cfg_r[`PTC_CFG_NPN];
    end
  end
endmodule

// ---- design/ptc_params.svh ----
// constants for the proximity temperature-compensation block
// assumes a single 10 MHz clock shared by both ends of the link
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// *******************
// clock and timing
// *******************
`define PTC_CLK_MHZ 10
`define PTC_BIT_US 10
`define PTC_BIT_CYC (`PTC_BIT_US * `PTC_CLK_MHZ)
`define PTC_HALF_CYC (`PTC_BIT_CYC / 2)
`define PTC_TEST_US 30
`define PTC_TEST_CYC (`PTC_TEST_US * `PTC_CLK_MHZ)
`define PTC_RETRY_US 10000
`define PTC_RETRY_CYC (`PTC_RETRY_US * `PTC_CLK_MHZ)
`define PTC_OC_MV 310

// *******************
// device register map
// *******************
`define PTC_A_THR_HI 8'h70
`define PTC_A_THR_LO 8'h71
`define PTC_A_CFG 8'h78
`define PTC_A_TEMP 8'h79
`define PTC_A_PROX_HI 8'h7a
`define PTC_A_PROX_LO 8'h7b
`define PTC_A_LUT 8'h80
`define PTC_CFG_NPN 0
`define PTC_CFG_LED5 1
`define PTC_THR_RST 16'h4000
`define PTC_TEMP_OFS 8'h40
`define PTC_PROX_FULL 16'h8000

// *******************
// gain table
// *******************
`define PTC_LUT_TMIN (-48)
`define PTC_LUT_TMAX 136
`define PTC_LUT_STEP 4
`define PTC_LUT_N 47
`define PTC_LUT_CODE0 8'h10
`define PTC_GAIN_FRAC 14
`define PTC_GAIN_RST 16'h4000

// *******************
// link framing and controller map
// *******************
`define PTC_FRAME_BITS 17
`define PTC_REPLY_BITS 8
`define PTC_C_TARGET 3'h0
`define PTC_C_WDATA 3'h1
`define PTC_C_CTRL 3'h2
`define PTC_C_RDATA 3'h3
`define PTC_C_STATUS 3'h4
`define PTC_C_MASK 3'h5
`define PTC_CTRL_GO 0
`define PTC_CTRL_WR 1
`define PTC_ST_DONE 0
`define PTC_ST_RDOK 1
`endif

// ---- design/ptc_pkg.sv ----
// types shared by both ends of the configuration link
// assumes ptc_params.svh for all numbers
package ptc_pkg;
  typedef logic [7:0] ptc_byte_t;
  typedef logic [15:0] ptc_word_t;
  typedef enum logic [1:0] {OL_RUN, OL_WAIT, OL_TEST} ptc_ol_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_BITS, RX_STOP, TX_START, TX_BITS
  } ptc_rx_t;
  typedef enum logic [2:0] {
    CT_IDLE, CT_SEND, CT_WAIT, CT_START, CT_BITS
  } ptc_ct_t;
endpackage

// ---- design/ptc_link_if.sv ----
// single-wire configuration line plus indicator reply path
// assumes the testbench instantiates it between both ends
`timescale 1ns/1ns
interface ptc_link_if;
  logic cfgOut;
  logic cfgOe;
  logic cfgLine;
  logic indSink;
  // line idles high when nobody drives it
  assign cfgLine = cfgOe ? cfgOut : 1'b1;
  modport dev (input cfgLine, output indSink);
  modport ctl (output cfgOut, output cfgOe, input indSink);
endinterface

// ---- design/ptc_controller.sv ----
// calibration controller end: software registers, frames, reply capture
// assumes software on the same clock and the device on the link
`timescale 1ns/1ns
`include "ptc_params.svh"
module ptc_controller (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  ptc_link_if.ctl link,
  // software port
  input wire logic [2:0] addr,
  input wire ptc_pkg::ptc_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output ptc_pkg::ptc_byte_t rdata,
  output logic irq
);
  import ptc_pkg::*;

  // *******************
  // reply pin synchroniser
  // *******************
  logic indMeta_r, indS_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      indMeta_r <= 1'b0;
      indS_r <= 1'b0;
    end else begin
      indMeta_r <= link.indSink;
      indS_r <= indMeta_r;
    end
  end

  // *******************
  // software registers
  // *******************
  ptc_byte_t target_r, wdat_r, rbyte_r;
  logic [1:0] status_r, mask_r, evt;
  logic goWr, busy;
  ptc_ct_t ct_r;
  assign busy = ct_r != CT_IDLE;
  assign goWr = wr && addr == `PTC_C_CTRL && wdata[`PTC_CTRL_GO] && !busy;

  always_ff @(posedge clock) begin
    if (rst) begin
      target_r <= 8'h00;
      wdat_r <= 8'h00;
      mask_r <= 2'b00;
    end else begin
      if (wr && addr == `PTC_C_TARGET) target_r <= wdata;
      if (wr && addr == `PTC_C_WDATA) wdat_r <= wdata;
      if (wr && addr == `PTC_C_MASK) mask_r <= wdata[1:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) status_r <= 2'b00;
    else if (wr && addr == `PTC_C_STATUS)
      status_r <= (status_r & ~wdata[1:0]) | evt;
    else status_r <= status_r | evt;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq <= |((status_r | evt) & mask_r);
      if (rd) begin
        unique case (addr)
          `PTC_C_TARGET: rdata <= target_r;
          `PTC_C_WDATA: rdata <= wdat_r;
          `PTC_C_CTRL: rdata <= {7'h00, busy};
          `PTC_C_RDATA: rdata <= rbyte_r;
          `PTC_C_STATUS: rdata <= {6'h00, status_r};
          `PTC_C_MASK: rdata <= {6'h00, mask_r};
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // *******************
  // frame sender and reply receiver
  // *******************
  logic [18:0] frm_r;
  logic [15:0] cnt_r;
  logic [4:0] bitCnt_r;
  logic isWr_r, cfgOut_r, cfgOe_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ct_r <= CT_IDLE;
      frm_r <= 19'h7ffff;
      cnt_r <= 16'h0000;
      bitCnt_r <= 5'h00;
      isWr_r <= 1'b0;
      cfgOut_r <= 1'b1;
      cfgOe_r <= 1'b0;
      rbyte_r <= 8'h00;
      evt <= 2'b00;
    end else begin
      evt <= 2'b00;
      unique case (ct_r)
        CT_IDLE: begin
          cfgOe_r <= 1'b0;
          cfgOut_r <= 1'b1;
          if (goWr) begin
            // start low, direction, address, data, stop high
            frm_r <= {1'b0, wdata[`PTC_CTRL_WR], target_r,
                      wdat_r, 1'b1};
            isWr_r <= wdata[`PTC_CTRL_WR];
            ct_r <= CT_SEND;
            cnt_r <= 16'h0000;
            bitCnt_r <= 5'h00;
          end
        end
        CT_SEND: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (bitCnt_r == 5'(`PTC_FRAME_BITS + 2)) begin
            cfgOe_r <= 1'b0;
            cfgOut_r <= 1'b1;
            ct_r <= isWr_r ? CT_IDLE : CT_WAIT;
            evt[`PTC_ST_DONE] <= isWr_r;
          end else begin
            cfgOe_r <= 1'b1;
            cfgOut_r <= frm_r[18];
            frm_r <= {frm_r[17:0], 1'b1};
            bitCnt_r <= bitCnt_r + 5'h01;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
          end
        end
        CT_WAIT: begin
          // no timeout: a silent device leaves the controller busy
          if (indS_r) begin
            ct_r <= CT_START;
            cnt_r <= 16'(`PTC_HALF_CYC - 1);
          end
        end
        CT_START: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            ct_r <= CT_BITS;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
            bitCnt_r <= 5'h00;
          end
        end
        CT_BITS: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            rbyte_r <= {rbyte_r[6:0], indS_r};
            bitCnt_r <= bitCnt_r + 5'h01;
            cnt_r <= 16'(`PTC_BIT_CYC - 1);
            if (bitCnt_r == 5'(`PTC_REPLY_BITS - 1)) begin
              ct_r <= CT_IDLE;
              evt <= 2'b11;
            end
          end
        end
        default: ct_r <= CT_IDLE;
      endcase
    end
  end
  assign link.cfgOut = cfgOut_r;
  assign link.cfgOe = cfgOe_r;
  // the controller software must itself
endmodule

// ---- dv/ptc_link_chk.sv ----
// link checker: controller framing and device reply shape
// assumes one clock; fed from the link interface signals
`timescale 1ns/1ns
module ptc_link_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  input wire logic cfgOut,
  input wire logic cfgOe,
  input wire logic indSink
);
  // ********
  // helpers
  // ********
  logic [11:0] oeCnt_r;
  logic [9:0] repCnt_r;
  logic sinkD_r;
  logic [11:0] rdAge_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // cycles the controller has driven the line in this frame
  always_ff @(posedge clock) begin
    if (rst) begin
      oeCnt_r <= 12'h0;
    end else begin
      oeCnt_r <= cfgOe ? oeCnt_r + 12'h1 : 12'h0;
    end
  end
  // reply age; data bits re-rise, so no restart inside a reply
  always_ff @(posedge clock) begin
    if (rst) begin
      sinkD_r <= 1'b0;
      repCnt_r <= 10'h0;
    end else begin
      sinkD_r <= indSink;
      if (repCnt_r != 10'h0) begin
        repCnt_r <= (repCnt_r == 10'h3e7) ? 10'h0 : repCnt_r + 10'h1;
      end else if (indSink && !sinkD_r) begin
        repCnt_r <= 10'h1;
      end
    end
  end
  // cycles since a read frame passed its direction bit
  always_ff @(posedge clock) begin
    if (rst) begin
      rdAge_r <= 12'h0;
    end else if (cfgOe && oeCnt_r == 12'h96 && !cfgOut) begin
      rdAge_r <= 12'h1;
    end else if (indSink) begin
      rdAge_r <= 12'h0;
    end else if (rdAge_r != 12'h0 && rdAge_r != 12'hfff) begin
      rdAge_r <= rdAge_r + 12'h1;
    end
  end
  // ********
  // assertions
  // ********
  sequence s_read_dir;
    cfgOe && oeCnt_r == 12'h96 && !cfgOut;
  endsequence
  sequence s_reply_due;
    indSink && rdAge_r != 12'h0;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    rst |=> !cfgOe && cfgOut && !indSink)
    else $error("link busy after reset");
  a_start_low: assert property (
    cfgOe && oeCnt_r < 12'h64 |-> !cfgOut)
    else $error("start bit not low");
  a_stop_high: assert property (
    cfgOe && oeCnt_r >= 12'h708 |-> cfgOut)
    else $error("stop bit not high");
  a_frame_len: assert property (
    $fell(cfgOe) |-> oeCnt_r inside {[12'h6a4:12'h76c]})
    else $error("frame length wrong");
  a_frame_bit_stable: assert property (
    cfgOe && oeCnt_r != 12'h0 && oeCnt_r % 12'h64 != 12'h0
    |-> $stable(cfgOut))
    else $error("line moved inside a bit");
  a_read_quiet: assert property (
    s_read_dir |-> !indSink)
    else $error("reply during a read frame");
  a_read_reply: assert property (
    s_reply_due |-> rdAge_r >= 12'h5aa && rdAge_r <= 12'h7d0)
    else $error("read reply outside its window");
  a_reply_due: assert property (
    rdAge_r <= 12'h7d0)
    else $error("no reply to a read");
  a_reply_start: assert property (
    repCnt_r != 10'h0 && repCnt_r < 10'h64 |-> indSink)
    else $error("reply start bit short");
  a_reply_bit_stable: assert property (
    repCnt_r % 10'h64 != 10'h0 |-> $stable(indSink))
    else $error("reply moved inside a bit");
  a_reply_end: assert property (
    repCnt_r >= 10'h384 |-> !indSink)
    else $error("reply not released");
endmodule

// ---- dv/proximity_temp_compensation_lut_tb.sv ----
// bench: controller and device joined over the link, software port driven
// assumes design files and the link checker are compiled before it
`timescale 1ns/1ns
`include "ptc_params.svh"
module proximity_temp_compensation_lut_tb;
  import ptc_pkg::*;
  // ********
  // wiring
  // ********
  logic clock;
  logic rst;
  logic signed [7:0] tempC;
  ptc_word_t proxRaw;
  logic highSideOver;
  logic lowSideOver;
  logic detect;
  logic switchDrive;
  logic ledOn;
  logic ledCurrentHigh;
  logic npnMode;
  logic [2:0] addr;
  ptc_byte_t wdata;
  logic wr;
  logic rd;
  ptc_byte_t rdata;
  logic irq;
  logic maskOn;
  int miscompares;
  int checked;
  localparam logic [7:0] TEMPS [6] = '{8'hd4, 8'hd3, 8'hd4, 8'h80, 8'hd4,
    8'hd0};
  localparam logic DETS [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  ptc_link_if link();
  // short retry gap keeps the overload run brief
  ptc_device #(.RETRY_CYC(500)) ptc_device_i (.clock(clock), .rst(rst),
    .link(link), .tempC(tempC), .proxRaw(proxRaw),
    .highSideOver(highSideOver), .lowSideOver(lowSideOver),
    .detect(detect), .switchDrive(switchDrive), .ledOn(ledOn),
    .ledCurrentHigh(ledCurrentHigh), .npnMode(npnMode));
  ptc_controller ptc_controller_i (.clock(clock), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  ptc_link_chk ptc_link_chk_i (.clock(clock), .rst(rst),
    .cfgOut(link.cfgOut), .cfgOe(link.cfgOe), .indSink(link.indSink));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  // ********
  // tasks
  // ********
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic swWrite(input logic [2:0] a, input ptc_byte_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic swRead(input logic [2:0] a, output ptc_byte_t d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic waitFor(input string what, ref logic s, input logic e,
                         input int lim);
    int n;
    n = 0;
    #1;
    while (s !== e && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(what, {15'h0, e}, {15'h0, s});
    if (s !== e) end_sim();
  endtask
  task automatic countRun(ref logic s, input logic v, output int n);
    n = 0;
    while (s === v && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      end_sim();
    end
  endtask
  // one link transaction; polls done, checks irq, clears status
  task automatic xfer(input ptc_byte_t a, input ptc_byte_t d,
                      input logic wrt, output ptc_byte_t q);
    ptc_byte_t st;
    int n;
    st = 8'h0;
    n = 0;
    swWrite(`PTC_C_TARGET, a);
    swWrite(`PTC_C_WDATA, d);
    swWrite(`PTC_C_CTRL, {6'h0, wrt, 1'b1});
    while (st[`PTC_ST_DONE] !== 1'b1 && n < 400) begin
      repeat (10) @(posedge clock);
      swRead(`PTC_C_STATUS, st);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      end_sim();
    end
    if (!wrt) check("read ok", 16'h1, {15'h0, st[`PTC_ST_RDOK]});
    @(posedge clock);
    #1;
    check("irq raised", {15'h0, maskOn}, {15'h0, irq});
    swWrite(`PTC_C_STATUS, 8'h03);
    swRead(`PTC_C_RDATA, q);
    check("irq cleared", 16'h0, {15'h0, irq});
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    ptc_byte_t q;
    int n;
    rst = 1'b1;
    tempC = 8'sh19;
    proxRaw = 16'h7fa5;
    highSideOver = 1'b0;
    lowSideOver = 1'b0;
    addr = 3'h0;
    wdata = 8'h0;
    wr = 1'b0;
    rd = 1'b0;
    maskOn = 1'b1;
    miscompares = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    swRead(3'h6, q);
    check("unmapped", 16'h0, {8'h0, q});
    check("irq after reset", 16'h0, {15'h0, irq});
    swWrite(`PTC_C_MASK, 8'h01);
    for (int i = 0; i < 2; i++) begin
      tempC <= TEMPS[i];
      xfer(`PTC_A_TEMP, 8'h0, 1'b0, q);
      check("temperature", {8'h0, TEMPS[i] + 8'h40}, {8'h0, q});
    end
    xfer(`PTC_A_PROX_HI, 8'h0, 1'b0, q);
    check("prox high", {8'h0, proxRaw[15:8]}, {8'h0, q});
    xfer(`PTC_A_PROX_LO, 8'h0, 1'b0, q);
    check("prox low", {8'h0, proxRaw[7:0]}, {8'h0, q});
    // last entry keeps its unity default
    xfer(`PTC_A_LUT + 8'h5c, 8'h0, 1'b0, q);
    check("default high", 16'h0040, {8'h0, q});
    xfer(`PTC_A_LUT + 8'h5d, 8'h0, 1'b0, q);
    check("default low", 16'h0000, {8'h0, q});
    // lowest slot takes the nearest gain, times 3 plus a little
    xfer(`PTC_A_LUT, 8'hc0, 1'b1, q);
    xfer(`PTC_A_LUT + 8'h1, 8'h34, 1'b1, q);
    xfer(`PTC_A_LUT + 8'h2, 8'h40, 1'b1, q);
    xfer(`PTC_A_LUT, 8'h0, 1'b0, q);
    check("entry high", 16'h00c0, {8'h0, q});
    xfer(`PTC_A_LUT + 8'h1, 8'h0, 1'b0, q);
    check("entry low", 16'h0034, {8'h0, q});
    // raw 0x1600 only passes 0x4000 with the tripled gain
    proxRaw <= 16'h1600;
    for (int i = 0; i < 6; i++) begin
      tempC <= TEMPS[i];
      waitFor("detect", detect, DETS[i], 20);
    end
    waitFor("indicator", ledOn, 1'b1, 5);
    xfer(`PTC_A_CFG, 8'h03, 1'b1, q);
    check("npn", 16'h1, {15'h0, npnMode});
    check("led 5ma", 16'h1, {15'h0, ledCurrentHigh});
    highSideOver <= 1'b1;
    repeat (20) @(posedge clock);
    waitFor("high side ignored", switchDrive, 1'b1, 1);
    lowSideOver <= 1'b1;
    waitFor("low side trips", switchDrive, 1'b0, 10);
    highSideOver <= 1'b0;
    lowSideOver <= 1'b0;
    waitFor("recovered", switchDrive, 1'b1, 1000);
    xfer(`PTC_A_CFG, 8'h00, 1'b1, q);
    check("pnp", 16'h0, {15'h0, npnMode});
    check("led 2.5ma", 16'h0, {15'h0, ledCurrentHigh});
    lowSideOver <= 1'b1;
    repeat (20) @(posedge clock);
    waitFor("low side ignored", switchDrive, 1'b1, 1);
    lowSideOver <= 1'b0;
    highSideOver <= 1'b1;
    waitFor("high side trips", switchDrive, 1'b0, 10);
    countRun(switchDrive, 1'b0, n);
    check("retry gap", 16'h1, {15'h0, n >= 495 && n <= 505});
    // overload still present: the pulse keeps its full length
    countRun(switchDrive, 1'b1, n);
    check("test pulse", 16'h012c, n[15:0]);
    highSideOver <= 1'b0;
    countRun(switchDrive, 1'b0, n);
    // a clean test pulse hands back to normal switching
    repeat (350) @(posedge clock);
    waitFor("back to normal", switchDrive, 1'b1, 1);
    // masked event: status still sets, irq stays low
    swWrite(`PTC_C_MASK, 8'h00);
    maskOn = 1'b0;
    xfer(`PTC_A_TEMP, 8'h0, 1'b0, q);
    end_sim();
  end
endmodule
